/* File: src/scpg_top.sv */
//Contract
// - loop multiplies, divides and phase-locks reference
// - writing one selects loop output chain
// - writing zero returns to bypass once output and both sources are low
// - mode changes never glitch the system clock
// - bypass source is strap: external or rtc
// - multiplier is four high plus low plus four
// - reference skip bit bypasses reference divider
// - output enable clear bypasses both output stages
// - output skip only bypasses programmable divider
// - clear bit low holds generator flops cleared
// - standby bit parks loop, software keeps clear
// - power-off bit stops loop, power-up relocks
// - registers are 16-bit words at 1c1e-1c24
// - loop mode refused while loop powered down
// - output divider divides by ratio plus four
// - reference divider divides by ratio plus four
`include "scpg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module scpg_top
  import scpg_pkg::*;
#(
  parameter int LOCK_CYCLES = `SCPG_LOCK_CYCLES,
  parameter int PW          = 24
) (
  input  wire logic          core_clk,
  input  wire logic          srst,
  input  wire logic [15:0]   io_addr,
  input  wire logic [15:0]   io_wdata,
  input  wire logic          io_wr,
  input  wire logic          io_rd,
  output var  scpg_word_type io_rdata,
  input  wire logic          external_clock_input,
  input  wire logic          rtc_clock,
  input  wire logic          clock_strap,
  output var  logic          system_clock,
  output var  logic          loop_output_clock,
  output var  logic          reference_clock,
  output var  logic          loop_locked,
  output var  logic          mode_active
);
  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CYCLES);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic        mode_select_reg;  // software's mode request
  logic        clear_n_reg;      // flipflop_clear_n
  logic        standby_reg;      // loop standby
  logic        power_off_reg;    // loop_power_off
  logic [9:0]  mh_reg;           // multiplier_high_field
  logic        ref_skip_reg;     // ref_divider_skip
  logic [1:0]  ml_reg;           // multiplier_low_field
  logic [11:0] rd_ratio_reg;     // ref_divider_ratio
  logic [15:0] init_reg;         // initialization word, bit 3 unused
  logic        od_en_reg;        // output_division_enable
  logic        od_skip_reg;      // output_divider_skip
  logic [5:0]  od_ratio_reg;     // output_divider_ratio
  logic [3:0]  pinsel_reg;       // clock pin source select, stored only
  logic        strap_reg;        // strap caught during reset

  // ---------------------------------------------------------------
  // datapath state
  // ---------------------------------------------------------------
  logic [2:0]    pins_sync;        // synchronised pins
  logic          ext_level;        // external clock after two flops
  logic          rtc_level;        // rtc clock after two flops
  logic          src_level;        // strap-selected bypass source
  logic          src_prev_reg;     // for rising edge of the source
  logic          src_rise;         // input clock rising edge tick
  logic          ref_tick;         // reference clock tick
  logic          loop_run;         // loop powered, active, not cleared
  logic [LW-1:0] lock_cnt_reg;     // cycles since loop start
  logic          locked;           // lock time has passed
  logic [PW-1:0] per_cnt_reg;      // cycles since last reference tick
  logic [PW-1:0] period_reg;       // measured reference period
  logic [PW:0]   acc_reg;          // oscillator phase accumulator
  logic [PW:0]   acc_sum;          // accumulator plus multiplier
  logic [13:0]   mult;             // loop multiplier
  logic          loop_tick_reg;    // loop output clock tick
  logic          half_reg;         // fixed divide-by-2 phase
  logic          fin_tick_reg;     // tick at end of output chain
  logic          post_od_tick;     // tick entering the fixed stage
  scpg_mode_type active_mode_reg;  // source actually driving now
  scpg_mode_type target_mode;      // source software asked for
  logic          target_level;     // level target would drive next
  logic          cur_level;        // level the active source drives now
  scpg_word_type rdata_next;       // read mux

  scpg_tick_if #(.W(12)) ref_if ();
  scpg_tick_if #(.W(6))  od_if  ();

  // ---------------------------------------------------------------
  // pin inputs: two flops before anything reads them
  // ---------------------------------------------------------------
  // sync keeps running through reset so the strap is valid when caught
  scpg_sync #(.W(3)) u_sync (
    .core_clk (core_clk),
    .srst     (1'b0),
    .pin_in   ({clock_strap, rtc_clock, external_clock_input}),
    .pin_sync (pins_sync)
  );

  assign ext_level = pins_sync[0];
  assign rtc_level = pins_sync[1];

  // strap is static; caught while reset is held so it never moves
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strap_reg <= pins_sync[2];
    end
  end

  // bypass source: external clock on strap high, else rtc
  assign src_level = strap_reg ? ext_level : rtc_level;

  // edge of the input clock, used as reference tick; reset high so a
  // source already high at release gives no false edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      src_prev_reg <= 1'b1;
    end else begin
      src_prev_reg <= src_level;
    end
  end

  assign src_rise = src_level & ~src_prev_reg;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // mode select: a request for loop mode is dropped while powered off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_select_reg <= 1'b0;
    end else if (io_wr && io_addr == `SCPG_ADDR_CFG2) begin
      if (!io_wdata[`SCPG_CFG2_MODE_BIT]) begin
        mode_select_reg <= 1'b0;
      end else if (!power_off_reg) begin
        mode_select_reg <= 1'b1;
      end // else refused, select keeps its value
    end
  end

  // loop_control_one: clear, standby, power, high multiplier
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clear_n_reg   <= 1'b0;
      standby_reg   <= 1'b1;
      power_off_reg <= 1'b0;
      mh_reg        <= '0;
    end else if (io_wr && io_addr == `SCPG_ADDR_CTL1) begin
      clear_n_reg   <= io_wdata[`SCPG_CTL1_CLEAR_BIT];
      standby_reg   <= io_wdata[`SCPG_CTL1_STANDBY_BIT];
      power_off_reg <= io_wdata[`SCPG_CTL1_POWER_BIT];
      mh_reg        <= io_wdata[`SCPG_CTL1_MH_MSB:0];
    end
  end

  // loop_control_two: reference skip, low multiplier, ref ratio
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ref_skip_reg <= 1'b0;
      ml_reg       <= '0;
      rd_ratio_reg <= '0;
    end else if (io_wr && io_addr == `SCPG_ADDR_CTL2) begin
      ref_skip_reg <= io_wdata[`SCPG_CTL2_SKIP_BIT];
      ml_reg       <= io_wdata[`SCPG_CTL2_ML_MSB:`SCPG_CTL2_ML_LSB];
      rd_ratio_reg <= io_wdata[`SCPG_CTL2_RD_MSB:0];
    end
  end

  // loop_control_three: initialization word, kept as written
  always_ff @(posedge core_clk) begin
    if (srst) begin
      init_reg <= `SCPG_CTL3_RESET;
    end else if (io_wr && io_addr == `SCPG_ADDR_CTL3) begin
      init_reg <= io_wdata;
    end
  end

  // loop_control_four: output stage controls
  always_ff @(posedge core_clk) begin
    if (srst) begin
      od_en_reg    <= 1'b0;
      od_skip_reg  <= 1'b0;
      od_ratio_reg <= '0;
    end else if (io_wr && io_addr == `SCPG_ADDR_CTL4) begin
      od_en_reg    <= io_wdata[`SCPG_CTL4_EN_BIT];
      od_skip_reg  <= io_wdata[`SCPG_CTL4_SKIP_BIT];
      od_ratio_reg <= io_wdata[`SCPG_CTL4_OD_MSB:0];
    end
  end

  // pin source select: stored for software, drives nothing here
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinsel_reg <= `SCPG_PINSEL_RESET;
    end else if (io_wr && io_addr == `SCPG_ADDR_PINSEL) begin
      pinsel_reg <= io_wdata[`SCPG_PINSEL_MSB:0];
    end
  end

  // ---------------------------------------------------------------
  // register reads; unlisted addresses read zero
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    case (io_addr)
      `SCPG_ADDR_CFG2: begin
        rdata_next[`SCPG_CFG2_MODE_BIT]  = mode_select_reg;
        rdata_next[`SCPG_CFG2_STRAP_BIT] = strap_reg;
        rdata_next[`SCPG_CFG2_SRC_MSB:`SCPG_CFG2_SRC_LSB] =
          {strap_reg, active_mode_reg == scpg_mode_loop};
      end
      `SCPG_ADDR_CTL1: begin
        rdata_next[`SCPG_CTL1_CLEAR_BIT]   = clear_n_reg;
        rdata_next[`SCPG_CTL1_STANDBY_BIT] = standby_reg;
        rdata_next[`SCPG_CTL1_POWER_BIT]   = power_off_reg;
        rdata_next[`SCPG_CTL1_MH_MSB:0]    = mh_reg;
      end
      `SCPG_ADDR_CTL2: begin
        rdata_next[`SCPG_CTL2_SKIP_BIT] = ref_skip_reg;
        rdata_next[`SCPG_CTL2_ML_MSB:`SCPG_CTL2_ML_LSB] = ml_reg;
        rdata_next[`SCPG_CTL2_RD_MSB:0] = rd_ratio_reg;
      end
      `SCPG_ADDR_CTL3: begin
        rdata_next = init_reg;
        rdata_next[`SCPG_CTL3_LOCK_BIT] = locked; // live lock status
      end
      `SCPG_ADDR_CTL4: begin
        rdata_next[`SCPG_CTL4_EN_BIT]   = od_en_reg;
        rdata_next[`SCPG_CTL4_SKIP_BIT] = od_skip_reg;
        rdata_next[`SCPG_CTL4_OD_MSB:0] = od_ratio_reg;
      end
      `SCPG_ADDR_PINSEL: begin
        rdata_next[`SCPG_PINSEL_MSB:0] = pinsel_reg;
      end
      default: begin
        rdata_next = '0; // reserved word reads zero
      end
    endcase
  end

  // read data is registered and holds until the next read
  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_rdata <= '0;
    end else if (io_rd) begin
      io_rdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // reference divider
  // ---------------------------------------------------------------
  assign ref_if.clr     = ~clear_n_reg;
  assign ref_if.tick_in = src_rise;
  assign ref_if.ratio   = rd_ratio_reg;

  scpg_tick_div #(.W(12), .OFFSET(`SCPG_DIV_OFFSET)) u_ref_div (
    .core_clk (core_clk),
    .srst     (srst),
    .bus      (ref_if)
  );

  // skip bit takes the input clock straight as reference
  assign ref_tick = ref_skip_reg ? src_rise : ref_if.tick_out;

  // ---------------------------------------------------------------
  // loop model: lock timer and phase-aligned oscillator
  // ---------------------------------------------------------------
  // standby or power-off stops the loop; cleared flops too
  assign loop_run = ~power_off_reg & ~standby_reg & clear_n_reg;

  // lock time restarts whenever the loop is (re)started
  always_ff @(posedge core_clk) begin
    if (srst || !loop_run) begin
      lock_cnt_reg <= '0;
    end else if (lock_cnt_reg != LOCK_LAST) begin
      lock_cnt_reg <= lock_cnt_reg + 1'b1;
    end
  end

  assign locked = (lock_cnt_reg == LOCK_LAST);

  // four times high field plus low field plus four
  assign mult    = {2'b00, mh_reg, ml_reg} + `SCPG_MULT_OFFSET;
  assign acc_sum = acc_reg + {{(PW + 1 - 14){1'b0}}, mult};

  // measure the reference period in core cycles, saturating
  always_ff @(posedge core_clk) begin
    if (srst || !loop_run) begin
      per_cnt_reg <= '0;
      period_reg  <= '0;
    end else if (ref_tick) begin
      per_cnt_reg <= '0;
      period_reg  <= per_cnt_reg + 1'b1;
    end else if (per_cnt_reg != '1) begin
      per_cnt_reg <= per_cnt_reg + 1'b1;
    end
  end

  // oscillator emits mult ticks per reference period; each
  // reference tick restarts its phase, which keeps it locked.
  // limitation: at most one tick per core cycle
  always_ff @(posedge core_clk) begin
    if (srst || !loop_run || period_reg == '0) begin
      acc_reg       <= '0;
      loop_tick_reg <= 1'b0;
    end else if (ref_tick) begin
      acc_reg       <= '0;
      loop_tick_reg <= 1'b1;
    end else if (acc_sum >= {1'b0, period_reg}) begin
      loop_tick_reg <= 1'b1;
      if (acc_sum - {1'b0, period_reg} >= {1'b0, period_reg}) begin
        acc_reg <= {1'b0, period_reg} - 1'b1; // overrun, saturate
      end else begin
        acc_reg <= acc_sum - {1'b0, period_reg};
      end
    end else begin
      loop_tick_reg <= 1'b0;
      acc_reg       <= acc_sum;
    end
  end

  // ---------------------------------------------------------------
  // output dividers
  // ---------------------------------------------------------------
  assign od_if.clr     = ~clear_n_reg;
  assign od_if.tick_in = loop_tick_reg;
  assign od_if.ratio   = od_ratio_reg;

  scpg_tick_div #(.W(6), .OFFSET(`SCPG_DIV_OFFSET)) u_out_div (
    .core_clk (core_clk),
    .srst     (srst),
    .bus      (od_if)
  );

  // skip picks the raw loop tick ahead of the fixed stage
  assign post_od_tick = od_skip_reg ? loop_tick_reg : od_if.tick_out;

  // fixed divide-by-2 and the enable that bypasses both stages
  always_ff @(posedge core_clk) begin
    if (srst || !clear_n_reg) begin
      half_reg     <= 1'b0;
      fin_tick_reg <= 1'b0;
    end else if (!od_en_reg) begin
      half_reg     <= 1'b0;
      fin_tick_reg <= loop_tick_reg;
    end else begin
      if (post_od_tick) begin
        half_reg <= ~half_reg;
      end
      fin_tick_reg <= post_od_tick & half_reg;
    end
  end

  // ---------------------------------------------------------------
  // glitch-free mode switch
  // ---------------------------------------------------------------
  assign target_mode  = mode_select_reg ? scpg_mode_loop : scpg_mode_bypass;
  assign target_level = (target_mode == scpg_mode_loop) ? fin_tick_reg
                                                        : src_level;
  assign cur_level    = (active_mode_reg == scpg_mode_loop) ? fin_tick_reg
                                                            : src_level;

  // hand over only while the output, the old source about to be shown
  // and the new source are all low, so no runt pulse can appear;
  // costs at most one low phase of latency
  always_ff @(posedge core_clk) begin
    if (srst) begin
      active_mode_reg <= scpg_mode_bypass;
    end else begin
      case (active_mode_reg)
        scpg_mode_bypass: begin
          if (target_mode == scpg_mode_loop && !system_clock
              && !cur_level && !target_level) begin
            active_mode_reg <= scpg_mode_loop;
          end
        end
        scpg_mode_loop: begin
          if (target_mode == scpg_mode_bypass && !system_clock
              && !cur_level && !target_level) begin
            active_mode_reg <= scpg_mode_bypass;
          end
        end
        default: begin
          active_mode_reg <= scpg_mode_bypass;
        end
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      system_clock      <= 1'b0;
      loop_output_clock <= 1'b0;
      reference_clock   <= 1'b0;
      loop_locked       <= 1'b0;
      mode_active       <= 1'b0;
    end else begin
      system_clock      <= cur_level;
      loop_output_clock <= loop_tick_reg;
      reference_clock   <= ref_tick;
      loop_locked       <= locked;
      mode_active       <= (active_mode_reg == scpg_mode_loop);
    end
  end
endmodule
`default_nettype wire

/* File: src/scpg_map.svh */
`ifndef SCPG_MAP_SVH
`define SCPG_MAP_SVH

// word addresses in the cpu i/o space
`define SCPG_ADDR_CFG1          16'h1c1e
`define SCPG_ADDR_CFG2          16'h1c1f
`define SCPG_ADDR_CTL1          16'h1c20
`define SCPG_ADDR_CTL2          16'h1c21
`define SCPG_ADDR_CTL3          16'h1c22
`define SCPG_ADDR_CTL4          16'h1c23
`define SCPG_ADDR_PINSEL        16'h1c24

// clock_config_two fields
`define SCPG_CFG2_MODE_BIT      0
`define SCPG_CFG2_STRAP_BIT     2
`define SCPG_CFG2_SRC_LSB       4
`define SCPG_CFG2_SRC_MSB       5
// loop_control_one fields
`define SCPG_CTL1_CLEAR_BIT     15
`define SCPG_CTL1_STANDBY_BIT   13
`define SCPG_CTL1_POWER_BIT     12
`define SCPG_CTL1_MH_MSB        9
// loop_control_two fields
`define SCPG_CTL2_SKIP_BIT      15
`define SCPG_CTL2_ML_MSB        13
`define SCPG_CTL2_ML_LSB        12
`define SCPG_CTL2_RD_MSB        11
// loop_control_three fields
`define SCPG_CTL3_LOCK_BIT      3
`define SCPG_CTL3_RESET         16'h0806
// loop_control_four fields
`define SCPG_CTL4_EN_BIT        9
`define SCPG_CTL4_SKIP_BIT      8
`define SCPG_CTL4_OD_MSB        5
// clock_pin_source_select fields
`define SCPG_PINSEL_MSB         3
`define SCPG_PINSEL_RESET       4'hb

// arithmetic offsets of the dividers and the multiplier
`define SCPG_DIV_OFFSET         4
`define SCPG_MULT_OFFSET        14'h0004

// timing
`define SCPG_LOCK_TIME_US       4000
`define SCPG_CLK_PERIOD_NS      100
`define SCPG_LOCK_CYCLES \
  ((`SCPG_LOCK_TIME_US * 1000) / `SCPG_CLK_PERIOD_NS)

`endif

/* File: src/scpg_pkg.sv */
package scpg_pkg;
  // which source drives the system clock right now
  typedef enum logic {
    scpg_mode_bypass,
    scpg_mode_loop
  } scpg_mode_type;

  // one cpu i/o word
  typedef logic [15:0] scpg_word_type;
endpackage

/* File: src/scpg_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries a tick stream, its ratio and its clear into a divider
interface scpg_tick_if #(
  parameter int W = 12
);
  logic         clr;      // hold divider cleared
  logic         tick_in;  // one-cycle input tick
  logic [W-1:0] ratio;    // ratio field, divides by ratio + offset
  logic         tick_out; // one-cycle output tick

  modport feed (output clr, output tick_in, output ratio, input tick_out);
  modport div  (input clr, input tick_in, input ratio, output tick_out);
endinterface
`default_nettype wire

/* File: src/scpg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin levels
module scpg_sync #(
  parameter int W = 3
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_reg; // first stage, read only by the second

  // second stage is the only reader of the first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_reg <= '0;
      pin_sync <= '0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: src/scpg_tick_div.sv */
`timescale 1ns/1ps
`default_nettype none
// programmable tick divider: one output tick per (ratio + offset) inputs
module scpg_tick_div #(
  parameter int W      = 12,
  parameter int OFFSET = 4
) (
  input  wire logic core_clk,
  input  wire logic srst,
  scpg_tick_if.div  bus
);
  localparam logic [W:0] LAST_ADD = (W+1)'(OFFSET - 1);

  logic [W:0] count_reg; // input ticks seen in this period
  logic       tick_reg;  // registered output tick

  assign bus.tick_out = tick_reg;

  // count input ticks; clear holds the count at zero
  always_ff @(posedge core_clk) begin
    if (srst || bus.clr) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (bus.tick_in) begin
        if (count_reg == {1'b0, bus.ratio} + LAST_ADD) begin
          count_reg <= '0;
          tick_reg  <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/scpg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module scpg_monitor
  import scpg_pkg::*;
#(
  parameter int LOCK_CYCLES = 20,
  parameter int PW          = 24
) (
  input wire logic          core_clk,
  input wire logic          srst,
  input wire logic [15:0]   io_addr,
  input wire logic [15:0]   io_wdata,
  input wire logic          io_wr,
  input wire logic          io_rd,
  input wire scpg_word_type io_rdata,
  input wire logic          external_clock_input,
  input wire logic          rtc_clock,
  input wire logic          clock_strap,
  input wire logic          system_clock,
  input wire logic          loop_output_clock,
  input wire logic          reference_clock,
  input wire logic          loop_locked,
  input wire logic          mode_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic off_reg; // shadow of the power-off bit
  // the bit is only reachable through the word at 1c20
  always_ff @(posedge core_clk) begin
    if (srst) begin
      off_reg <= 1'b0;
    end else if (io_wr && io_addr == 16'h1c20) begin
      off_reg <= io_wdata[12];
    end
  end
  sequence s_rd_ctl3;
    io_rd && io_addr == 16'h1c22;
  endsequence
  sequence s_off_held;
    off_reg [*3];
  endsequence
  a_read_holds: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (io_rd && (io_addr < 16'h1c1f ||
    io_addr > 16'h1c24) |=> io_rdata == 16'h0000)
    else $error("reserved word read not zero");
  a_lock_echo: assert property (s_rd_ctl3 |=>
    io_rdata[3] == loop_locked)
    else $error("lock status bit wrong");
  a_refuse_off: assert property (off_reg && !mode_active |=>
    !mode_active)
    else $error("loop mode entered while powered down");
  a_switch_low: assert property ($changed(mode_active) |->
    !$past(system_clock))
    else $error("mode changed while clock high");
  a_ref_single: assert property (reference_clock |=>
    !reference_clock)
    else $error("reference tick longer than one cycle");
  a_off_quiet: assert property (s_off_held |->
    !loop_output_clock && !loop_locked)
    else $error("loop runs while powered down");
  a_active_echo: assert property (io_rd && io_addr == 16'h1c1f |=>
    io_rdata[4] == mode_active)
    else $error("active source bit wrong");
endmodule
bind scpg_top scpg_monitor #(.LOCK_CYCLES(LOCK_CYCLES), .PW(PW)) u_mon (
  .core_clk(core_clk), .srst(srst), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
  .external_clock_input(external_clock_input), .rtc_clock(rtc_clock),
  .clock_strap(clock_strap), .system_clock(system_clock),
  .loop_output_clock(loop_output_clock), .reference_clock(reference_clock),
  .loop_locked(loop_locked), .mode_active(mode_active));
`default_nettype wire

/* File: dv/tb_scpg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_scpg_top
  import scpg_pkg::*;
;
  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } scpg_row_type;
  logic          core_clk = 1'b0;
  logic          srst     = 1'b1;
  logic          io_wr    = 1'b0;
  logic          io_rd    = 1'b0;
  logic          ext_clk  = 1'b0;
  logic          rtc_clk  = 1'b0;
  logic          sys_q    = 1'b0;
  logic          strap    = 1'b1;
  logic [15:0]   io_addr  = 16'h0000;
  logic [15:0]   io_wdata = 16'h0000;
  scpg_word_type io_rdata;
  logic          sys_clk, loop_clk, ref_clk, locked, active;
  int            fail_count = 0;
  int            samples_checked = 0;
  int            ph = 0, n_ext = 0, n_ref = 0, n_loop = 0, n_sys = 0, k;
  int            n_rtc = 0;
  // reset values, access kinds, then a refused mode write
  scpg_row_type rows [0:14] = '{
    {1'b0, 16'h1c1f, 16'h0000, 16'h0024}, {1'b0, 16'h1c20, 16'h0000, 16'h2000},
    {1'b0, 16'h1c21, 16'h0000, 16'h0000}, {1'b0, 16'h1c22, 16'h0000, 16'h0806},
    {1'b0, 16'h1c23, 16'h0000, 16'h0000}, {1'b0, 16'h1c24, 16'h0000, 16'h000b},
    {1'b0, 16'h1c1e, 16'h0000, 16'h0000}, {1'b1, 16'h1c20, 16'hdfff, 16'h93ff},
    {1'b1, 16'h1c21, 16'hffff, 16'hbfff}, {1'b1, 16'h1c22, 16'hffff, 16'hfff7},
    {1'b1, 16'h1c23, 16'hffff, 16'h033f}, {1'b1, 16'h1c24, 16'hffff, 16'h000f},
    {1'b1, 16'h1c1e, 16'h0000, 16'h0000}, {1'b0, 16'h1c25, 16'h0000, 16'h0000},
    {1'b1, 16'h1c1f, 16'h0001, 16'h0024}};
  // short lock count keeps the run brief
  scpg_top #(.LOCK_CYCLES(20)) DUT (.core_clk(core_clk), .srst(srst),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .external_clock_input(ext_clk),
    .rtc_clock(rtc_clk), .clock_strap(strap), .system_clock(sys_clk),
    .loop_output_clock(loop_clk), .reference_clock(ref_clk),
    .loop_locked(locked), .mode_active(active));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // slow pins and tick counters; external pin period is 40 cycles
  always @(posedge core_clk) begin
    ph <= ph + 1;
    if (ph % 20 == 19) begin
      ext_clk <= ~ext_clk;
      n_ext <= n_ext + int'(!ext_clk);
    end
    if (ph % 30 == 29) begin
      rtc_clk <= ~rtc_clk;
      n_rtc <= n_rtc + int'(!rtc_clk);
    end
    sys_q <= sys_clk;
    n_ref <= n_ref + int'(ref_clk === 1'b1);
    n_loop <= n_loop + int'(loop_clk === 1'b1);
    n_sys <= n_sys + int'(sys_clk === 1'b1 && sys_q !== 1'b1);
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(logic [15:0] a, logic [15:0] e);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    @(posedge core_clk);
    check("read word", io_rdata, e);
  endtask
  task automatic wait_on(ref logic s, input logic v, input string what);
    for (int i = 0; i < 500 && s !== v; i++) @(posedge core_clk);
    check(what, {15'h0, s}, {15'h0, v});
  endtask
  // a counts about d times b over w cycles
  task automatic ratio(string what, ref int a, ref int b, input int w, d);
    int a0, b0, e;
    a0 = a;
    b0 = b;
    repeat (w) @(posedge core_clk);
    e = (a - a0) - (b - b0) * d;
    check(what, {15'h0, e <= d && e >= -d && b > b0 + 2}, 16'h0001);
  endtask
  // outputs may only change while the system clock is on bypass
  task automatic set_out(logic [15:0] v);
    wr(16'h1c1f, 16'h0000);
    wait_on(active, 1'b0, "bypass");
    wr(16'h1c23, v);
    wr(16'h1c1f, 16'h0001);
    wait_on(active, 1'b1, "loop");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end
      rdchk(rows[i].a, rows[i].e);
    end
    wr(16'h1c20, 16'h0000);
    wr(16'h1c21, 16'h0000);
    wr(16'h1c23, 16'h0000);
    wr(16'h1c22, 16'h0806);
    wr(16'h1c20, 16'h8001);
    wait_on(locked, 1'b1, "lock");
    rdchk(16'h1c22, 16'h080e);
    ratio("ref div", n_ext, n_ref, 1600, 4);
    ratio("mult", n_loop, n_ref, 1600, 8);
    wr(16'h1c21, 16'h8000);
    ratio("ref skip", n_ext, n_ref, 800, 1);
    wr(16'h1c1f, 16'h0001);
    wait_on(active, 1'b1, "loop");
    rdchk(16'h1c1f, 16'h0035);
    ratio("out off", n_loop, n_sys, 800, 1);
    set_out(16'h0300);
    ratio("fixed half", n_loop, n_sys, 800, 2);
    set_out(16'h0202);
    ratio("out div", n_loop, n_sys, 2400, 12);
    wr(16'h1c1f, 16'h0000);
    wait_on(active, 1'b0, "bypass");
    ratio("bypass", n_ext, n_sys, 800, 1);
    rdchk(16'h1c1f, 16'h0024);
    wr(16'h1c20, 16'h0001);
    repeat (4) @(posedge core_clk); // let ticks in flight drain
    k = n_loop;
    repeat (200) @(posedge core_clk);
    check("cleared lock", {15'h0, locked}, 16'h0000);
    check("cleared ticks", 16'(n_loop - k), 16'h0000);
    srst <= 1'b1;
    strap <= 1'b0; // restart with the rtc strapped in
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rdchk(16'h1c20, 16'h2000);
    rdchk(16'h1c1f, 16'h0000);
    ratio("rtc bypass", n_rtc, n_sys, 1200, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
